// File: core/prioritized_vectored_interrupt_unit.sv
// Interrupt unit: request flags, enables, priority pick, vector and entry sequence.
// Assumes the core pulses instr_done at each instruction end and interrupt_accept
// when it takes the presented request; source events are synchronous pulses.
// Return from an interrupt is the core's business: the saved registers only
// change on the next entry at the same level, and the level is only set here on entry (1 for maskable or software, 2 for watchdog).
`timescale 1ns/10ps
module prioritized_vectored_interrupt_unit (
	input  wire logic                                 clk,
	input  wire logic                                 reset_n,
	input  wire logic [irq_unit_pkg::NUM_MASKABLE-1:0] source_events,
	input  wire logic                                 watchdog_irq,
	input  wire logic                                 flag_write,
	input  wire logic [irq_unit_pkg::NUM_MASKABLE-1:0] flag_wdata,
	input  wire logic                                 enable_write,
	input  wire logic [irq_unit_pkg::NUM_MASKABLE-1:0] enable_wdata,
	input  wire logic                                 master_write,
	input  wire logic                                 master_wdata,
	input  wire logic                                 instr_done,
	input  wire logic                                 interrupt_accept,
	input  wire logic                                 software_irq_instr,
	input  wire logic [irq_unit_pkg::SWI_W-1:0]        software_irq_operand,
	input  wire logic [irq_unit_pkg::PC_W-1:0]         program_counter,
	input  wire logic [irq_unit_pkg::SEG_W-1:0]        code_segment_reg,
	input  wire logic [irq_unit_pkg::PSW_W-1:0]        program_status_word,
	output logic                                      irq_request,
	output logic      [irq_unit_pkg::VEC_W-1:0]        irq_vector,
	output logic                                      irq_nonmaskable,
	output logic                                      pc_load,
	output logic      [irq_unit_pkg::PC_W-1:0]         pc_load_value,
	output logic      [irq_unit_pkg::NUM_MASKABLE-1:0] request_flag_reg,
	output logic      [irq_unit_pkg::NUM_MASKABLE-1:0] source_enable_regs,
	output logic                                      master_irq_enable,
	output logic      [1:0]                           exception_level,
	output logic      [irq_unit_pkg::PC_W-1:0]         level1_return_addr,
	output logic      [irq_unit_pkg::SEG_W-1:0]        level1_saved_segment,
	output logic      [irq_unit_pkg::PSW_W-1:0]        level1_saved_status,
	output logic      [irq_unit_pkg::PC_W-1:0]         level2_return_addr,
	output logic      [irq_unit_pkg::SEG_W-1:0]        level2_saved_segment,
	output logic      [irq_unit_pkg::PSW_W-1:0]        level2_saved_status
);
	// All state lives in one struct so that the next-state logic is a single
	// combinational copy; every output is then a plain field of the register
	// and no output is ever decoded after the flip-flops.
	typedef struct packed {
		irq_unit_pkg::irq_state_t                  state;
		logic [irq_unit_pkg::NUM_MASKABLE-1:0]     flags;
		logic [irq_unit_pkg::NUM_MASKABLE-1:0]     enables;
		logic                                      master;
		logic [1:0]                                level;
		logic                                      request;
		logic [irq_unit_pkg::VEC_W-1:0]            vector;
		logic                                      nmi;
		logic [irq_unit_pkg::IDX_W-1:0]            index;
		logic                                      pc_load;
		logic [irq_unit_pkg::PC_W-1:0]             pc_value;
		logic [irq_unit_pkg::PC_W-1:0]             l1_pc;
		logic [irq_unit_pkg::SEG_W-1:0]            l1_seg;
		logic [irq_unit_pkg::PSW_W-1:0]            l1_psw;
		logic [irq_unit_pkg::PC_W-1:0]             l2_pc;
		logic [irq_unit_pkg::SEG_W-1:0]            l2_seg;
		logic [irq_unit_pkg::PSW_W-1:0]            l2_psw;
		logic                                      wdt_pend;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic   found;
	logic [irq_unit_pkg::IDX_W-1:0] pick;
	logic [irq_unit_pkg::NUM_MASKABLE-1:0] eligible;

	// Lowest index wins, scanning from the top index down
	// A plain loop keeps the table order as the only source of priority;
	// a tree would be faster but harder to keep in step with the vectors.
	always_comb begin
		eligible = s_reg.flags & s_reg.enables & {irq_unit_pkg::NUM_MASKABLE{s_reg.master}};
		found = 1'b0;
		pick  = '0;
		for (int i = irq_unit_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				found = 1'b1;
				pick  = irq_unit_pkg::IDX_W'(i);
			end
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.pc_load = 1'b0;
		// Set beats clear: events and software writes are merged after acceptance
		if (interrupt_accept && s_reg.request && !s_reg.nmi) begin
			s_next.flags[s_reg.index] = 1'b0;
		end
		if (flag_write) begin
			s_next.flags = flag_wdata;
		end
		s_next.flags = s_next.flags | source_events;
		if (enable_write) begin
			s_next.enables = enable_wdata;
		end
		if (master_write) begin
			s_next.master = master_wdata;
		end
		s_next.wdt_pend = s_reg.wdt_pend | watchdog_irq;

		// The hold window lasts until the next instr_done after a flag, enable or master write
		case (s_reg.state)
			irq_unit_pkg::ST_RUN: begin
				if (flag_write || enable_write || master_write) begin
					s_next.state = irq_unit_pkg::ST_HOLD;
				end
			end
			irq_unit_pkg::ST_HOLD: begin
				if (instr_done) begin
					s_next.state = irq_unit_pkg::ST_RUN;
				end
			end
			default: s_next.state = irq_unit_pkg::ST_RUN;
		endcase

		// Presented request is recomputed every cycle until the core takes it
		// The watchdog is checked first and ignores the hold window and the
		// master enable, so it preempts a maskable handler at any time.
		// A maskable request that is already presented may be replaced by a
		// better one; the core always takes whatever stands on its accept edge.
		s_next.request = 1'b0;
		s_next.nmi     = 1'b0;
		if (s_reg.wdt_pend) begin
			s_next.request = 1'b1;
			s_next.nmi     = 1'b1;
			s_next.vector  = irq_unit_pkg::WDT_VECTOR;
		end else if (found && s_next.state == irq_unit_pkg::ST_RUN
				&& s_reg.state == irq_unit_pkg::ST_RUN && s_next.master) begin
			s_next.request = 1'b1;
			s_next.index   = pick;
			s_next.vector  = irq_unit_pkg::VECTORS[pick];
		end


		// Entry sequence: state is saved from the core's values on the accept
		// edge, and the jump target is the vector that stood at that edge.
		// The presented request drops for one cycle so the core never sees a
		// stale request for the source it has just taken.
		if (interrupt_accept && s_reg.request) begin
			s_next.request  = 1'b0;
			s_next.pc_load  = 1'b1;
			s_next.pc_value = s_reg.vector;
			if (s_reg.nmi) begin
				s_next.wdt_pend = watchdog_irq;
				s_next.l2_pc  = program_counter;
				s_next.l2_seg = code_segment_reg;
				s_next.l2_psw = program_status_word;
				s_next.level  = irq_unit_pkg::LEVEL_TWO;
			end else begin
				s_next.l1_pc  = program_counter;
				s_next.l1_seg = code_segment_reg;
				s_next.l1_psw = program_status_word;
				s_next.master = 1'b0;
				s_next.level  = irq_unit_pkg::LEVEL_ONE;
			end
		end else if (software_irq_instr) begin
			// A software trap is taken at once and ignores the master enable
			// A hardware accept in the same cycle wins; the core must then
			// execute the trap again after the handler returns.
			s_next.request  = 1'b0;
			s_next.pc_load  = 1'b1;
			s_next.pc_value = irq_unit_pkg::SWI_BASE
				+ {irq_unit_pkg::PC_W'(software_irq_operand) << 1};
			s_next.l1_pc    = program_counter;
			s_next.l1_seg   = code_segment_reg;
			s_next.l1_psw   = program_status_word;
			s_next.master   = 1'b0;
			s_next.level    = irq_unit_pkg::LEVEL_ONE;
		end
	end


	// Reset clears everything, which leaves the unit idle, all sources
	// masked and the master enable off until software turns it on.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end


	// Outputs come straight from the state register
	assign irq_request          = s_reg.request;
	assign irq_vector           = s_reg.vector;
	assign irq_nonmaskable      = s_reg.nmi;
	assign pc_load              = s_reg.pc_load;
	assign pc_load_value        = s_reg.pc_value;
	assign request_flag_reg     = s_reg.flags;
	assign source_enable_regs   = s_reg.enables;
	assign master_irq_enable    = s_reg.master;
	assign exception_level      = s_reg.level;
	assign level1_return_addr   = s_reg.l1_pc;
	assign level1_saved_segment = s_reg.l1_seg;
	assign level1_saved_status  = s_reg.l1_psw;
	assign level2_return_addr   = s_reg.l2_pc;
	assign level2_saved_segment = s_reg.l2_seg;
	assign level2_saved_status  = s_reg.l2_psw;
endmodule // prioritized_vectored_interrupt_unit

// File: core/irq_unit_pkg.sv
// Constants for the prioritized vectored interrupt unit.
// Assumes a 16-bit program counter, 4-bit code segment and 8-bit status word.
package irq_unit_pkg;
	localparam int NUM_MASKABLE = 29;
	localparam int VEC_W        = 16;
	localparam int PC_W         = 16;
	localparam int SEG_W        = 4;
	localparam int PSW_W        = 8;
	localparam int IDX_W        = 5;
	localparam int SWI_W        = 6;
	// Watchdog vector, top priority
	localparam logic [VEC_W-1:0] WDT_VECTOR = 16'h0008;
	// Software interrupt table base; operand n selects entry base + 2n
	localparam logic [VEC_W-1:0] SWI_BASE   = 16'h0080;
	// Maskable vectors, index 0 is priority 2 and index 28 is priority 30
	localparam logic [VEC_W-1:0] VECTORS [NUM_MASKABLE] = '{
		16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
		16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h002a, 16'h002c, 16'h002e,
		16'h0030, 16'h0032, 16'h0038, 16'h003a, 16'h0040, 16'h0042, 16'h0058,
		16'h005a, 16'h0060, 16'h0062, 16'h0064, 16'h006a, 16'h006e, 16'h0070,
		16'h0076};
	localparam int IDX_SERIAL_PORT0 = 8;
	localparam int IDX_SERIAL_PORT1 = 9;
	localparam int IDX_CONVERTER    = 10;
	localparam int IDX_FLASH        = 11;
	localparam logic [1:0] LEVEL_NONE = 2'h0;
	localparam logic [1:0] LEVEL_ONE  = 2'h1;
	localparam logic [1:0] LEVEL_TWO  = 2'h2;
	typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_ENTRY} irq_state_t;
endpackage

// File: verification/irq_unit_properties.sv
// Port checks for the interrupt unit.
// Assumes a bind to the unit's top module; one clock.
`timescale 1ns/10ps
module irq_unit_properties (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [28:0] source_events,
	input wire logic        watchdog_irq,
	input wire logic        interrupt_accept,
	input wire logic        software_irq_instr,
	input wire logic [5:0]  software_irq_operand,
	input wire logic [15:0] program_counter,
	input wire logic        irq_request,
	input wire logic [15:0] irq_vector,
	input wire logic        irq_nonmaskable,
	input wire logic        pc_load,
	input wire logic [15:0] pc_load_value,
	input wire logic [28:0] request_flag_reg,
	input wire logic [28:0] source_enable_regs,
	input wire logic        master_irq_enable,
	input wire logic [1:0]  exception_level,
	input wire logic [15:0] level1_return_addr,
	input wire logic [15:0] level2_return_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence take_s; interrupt_accept && irq_request; endsequence
	sequence mtake_s; take_s ##0 !irq_nonmaskable; endsequence
	sequence ntake_s; take_s ##0 irq_nonmaskable; endsequence
	chk_vector_load: assert property (take_s |=> pc_load && pc_load_value == $past(irq_vector))
		else $error("vector not loaded");
	chk_gated_request: assert property (irq_request && !irq_nonmaskable |->
		$past(master_irq_enable && |(request_flag_reg & source_enable_regs))) else $error("ungated");
	chk_level1_entry: assert property (mtake_s |=> !master_irq_enable && exception_level == 2'h1
		&& level1_return_addr == $past(program_counter)) else $error("bad level1 entry");
	chk_level2_entry: assert property (ntake_s |=> exception_level == 2'h2 && level2_return_addr ==
		$past(program_counter) && master_irq_enable == $past(master_irq_enable)) else $error("bad nmi");
	chk_wdt_vector: assert property (irq_request && irq_nonmaskable |-> irq_vector == 16'h0008)
		else $error("bad nmi vector");
	chk_wdt_first: assert property (watchdog_irq && !interrupt_accept && !irq_request |-> ##2
		(irq_request && irq_nonmaskable)) else $error("nmi not presented");
	chk_swi_entry: assert property (software_irq_instr && !(interrupt_accept && irq_request) |=> pc_load
		&& pc_load_value == 16'h0080 + {$past(software_irq_operand), 1'h0}) else $error("bad swi");
	chk_flag_set: assert property (|source_events |=>
		(request_flag_reg & $past(source_events)) == $past(source_events)) else $error("flag not set");
endmodule // irq_unit_properties

// File: verification/cpu_core_model.sv
// Core model: takes presented requests, ends an instruction every other cycle.
// Assumes the unit drops its request after an accepted one.
`timescale 1ns/10ps
module cpu_core_model (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic irq_request,
	input  wire logic slow,
	output logic      interrupt_accept,
	output logic      instr_done
);
	logic [2:0] wait_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_reg <= 3'h0;
			interrupt_accept <= 1'h0;
			instr_done <= 1'h0;
		end else begin
			instr_done <= ~instr_done;
			// Slow mode lets a request stand a while, so priority is re-picked under it
			interrupt_accept <= irq_request && !interrupt_accept && wait_reg >= (slow ? 3'h4 : 3'h0);
			wait_reg <= (irq_request && !interrupt_accept) ? wait_reg + 3'h1 : 3'h0;
		end
	end
endmodule // cpu_core_model

// File: verification/prioritized_vectored_interrupt_unit_tb_top.sv
// Bench for the interrupt unit with a core model.
// Assumes the checker and core model files are compiled first.
`timescale 1ns/10ps
module prioritized_vectored_interrupt_unit_tb_top;
	logic        clk = 1'h0, reset_n = 1'h0, slow = 1'h0, watchdog_irq = 1'h0;
	logic        flag_write = 1'h0, enable_write = 1'h0, master_write = 1'h0;
	logic        master_wdata = 1'h0, software_irq_instr = 1'h0;
	logic [28:0] source_events = 29'h0, flag_wdata = 29'h0, enable_wdata = 29'h0;
	logic [5:0]  software_irq_operand = 6'h0;
	logic [15:0] program_counter = 16'h1234;
	logic [3:0]  code_segment_reg = 4'h5, level1_saved_segment, level2_saved_segment;
	logic [7:0]  program_status_word = 8'ha5, level1_saved_status, level2_saved_status;
	logic        instr_done, interrupt_accept, irq_request, irq_nonmaskable, pc_load;
	logic        master_irq_enable;
	logic [15:0] irq_vector, pc_load_value, level1_return_addr, level2_return_addr;
	logic [28:0] request_flag_reg, source_enable_regs;
	logic [1:0]  exception_level;
	int          fails = 0, compares = 0;
	logic [15:0] vecs [5] = '{16'h0020, 16'h0022, 16'h0024, 16'h002a, 16'h0076};
	prioritized_vectored_interrupt_unit u_prioritized_vectored_interrupt_unit (.*);
	cpu_core_model u_cpu_core_model (.*);
	initial forever #50 clk = ~clk;
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic set_master(input logic v);
		@(posedge clk);
		master_write <= 1'h1;
		master_wdata <= v;
		@(posedge clk);
		master_write <= 1'h0;
	endtask
	// Waits for the jump, then checks vector, level and the saved core state
	task automatic entry(input logic [15:0] v, input logic [1:0] lv);
		int n;
		n = 0;
		do @(negedge clk); while (pc_load !== 1'h1 && ++n < 60);
		check("vector", v, pc_load_value);
		check("level", lv, exception_level);
		check("saved", 28'h1234_5a5, lv[1] ? {level2_return_addr, level2_saved_segment,
			level2_saved_status} : {level1_return_addr, level1_saved_segment, level1_saved_status});
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		enable_write <= 1'h1;
		enable_wdata <= 29'h1fffffff;
		@(posedge clk);
		enable_write <= 1'h0;
		set_master(1'h1);
		source_events <= 29'h10000f00;
		@(posedge clk);
		source_events <= 29'h0;
		foreach (vecs[i]) begin
			entry(vecs[i], 2'h1);
			set_master(1'h1);
		end
		check("flags", 29'h0, request_flag_reg);
		set_master(1'h0);
		slow <= 1'h1;
		flag_write <= 1'h1;
		flag_wdata <= 29'h1;
		@(posedge clk);
		flag_write <= 1'h0;
		repeat (8) @(negedge clk);
		check("held", 1'h0, irq_request);
		check("flag", 29'h1, request_flag_reg);
		set_master(1'h1);
		entry(16'h0010, 2'h1);
		watchdog_irq <= 1'h1;
		@(posedge clk);
		watchdog_irq <= 1'h0;
		entry(16'h0008, 2'h2);
		check("kept", 1'h0, master_irq_enable);
		set_master(1'h1);
		software_irq_instr <= 1'h1;
		software_irq_operand <= 6'h3f;
		@(posedge clk);
		software_irq_instr <= 1'h0;
		entry(16'h00fe, 2'h1);
		check("master", 1'h0, master_irq_enable);
		complete_run;
	end
	initial begin
		#400000;
		fails++;
		complete_run;
	end
endmodule // prioritized_vectored_interrupt_unit_tb_top
bind prioritized_vectored_interrupt_unit irq_unit_properties u_irq_unit_properties (.*);
